// File: rtl/boot_strap_pin_defaults.v
`timescale 1ns/1ns
`default_nettype none
`include "boot_strap_map.vh"

module boot_strap_pin_defaults #(
   parameter [31:0] RESET_HOLD_CYCLES = `RESET_HOLD_CYCLES,
   parameter [31:0] CAL_INTERVAL_CYCLES = `CAL_INTERVAL_CYCLES
)
(
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Reset and strap pins
   input wire system_reset_low,
   input wire ota_download_strap,
   input wire run_mode_strap_low,
   // Firmware status and requests
   input wire script_stored,
   input wire uart_open,
   input wire spi_open,
   input wire i2c_open,
   input wire flash_open,
   input wire rc_osc_in_use,
   input wire cmd_request,
   input wire script_load_request,
   // Software pin configuration
   input wire [`PIN_COUNT-1:0] sw_cfg_write,
   input wire [`PIN_COUNT-1:0] sw_oe,
   input wire [`PIN_COUNT-1:0] sw_out,
   input wire [`PIN_COUNT-1:0] sw_pull_up,
   input wire [`PIN_COUNT-1:0] sw_pull_dn,
   // Peripheral signals routed onto pins
   input wire uart_tx,
   input wire uart_rts_low,
   input wire spi_clk,
   input wire spi_dout,
   input wire i2c_scl_oe,
   input wire i2c_sda_oe,
   input wire flash_clk,
   input wire flash_dout,
   input wire flash_sel_low,
   // Pin pads
   input wire [`PIN_COUNT-1:0] pin_in,
   output reg [`PIN_COUNT-1:0] pin_out,
   output reg [`PIN_COUNT-1:0] pin_oe,
   output reg [`PIN_COUNT-1:0] pin_pull_up,
   output reg [`PIN_COUNT-1:0] pin_pull_dn,
   // Peripheral inputs from pins
   output wire uart_rx,
   output wire uart_cts_low,
   output wire flash_din,
   // Status
   output reg [`MODE_WIDTH-1:0] boot_mode,
   output reg module_reset,
   output reg bridge_active,
   output wire cmd_accept,
   output wire script_load_accept,
   output reg rc_cal_pulse
);

////////////////////////////////////////////////////////////////////////////////

localparam ST_HOLD = 3'b001;
localparam ST_SAMPLE = 3'b010;
localparam ST_RUN = 3'b100;

reg [2:0] state_reg;
reg [31:0] hold_cnt_reg;
reg ota_reg;
reg run_low_reg;
reg [`PIN_COUNT-1:0] cfg_oe_reg;
reg [`PIN_COUNT-1:0] cfg_out_reg;
reg [`PIN_COUNT-1:0] cfg_up_reg;
reg [`PIN_COUNT-1:0] cfg_dn_reg;
wire [2:0] strap_sync;
wire [`PIN_COUNT-1:0] pin_sync;
wire cal_tick;
wire reset_low_seen;
wire uart_on;
wire [`PIN_COUNT-1:0] alt_mask;

pin_sync2 #(
   .WIDTH(3),
   .INIT(3'b100)
) u_strap_sync (
   .clk_sys(clk_sys),
   .srst(1'b0), // Kept out of reset so the straps have settled when reset ends.
   .async_in({system_reset_low, ota_download_strap, run_mode_strap_low}),
   .sync_out(strap_sync)
);

pin_sync2 #(
   .WIDTH(`PIN_COUNT),
   .INIT(32'h0000_0000)
) u_pin_sync (
   .clk_sys(clk_sys),
   .srst(1'b0), // A reset value here would fake a start bit on receive.
   .async_in(pin_in),
   .sync_out(pin_sync)
);

assign reset_low_seen = !strap_sync[2];

////////////////////////////////////////////////////////////////////////////////
// Reset pin qualification and strap capture.

// A glitch shorter than the hold time never resets the pins, since the count
// restarts whenever the pin returns high before the hold is reached.
always @(posedge clk_sys)
begin
   if (srst)
   begin
      state_reg <= ST_SAMPLE;
      hold_cnt_reg <= 32'h0000_0000;
      module_reset <= 1'b1;
      ota_reg <= 1'b0;
      run_low_reg <= 1'b0;
   end
   else
   begin
      case (state_reg)
         ST_HOLD:
         begin
            module_reset <= 1'b1;
            if (!reset_low_seen)
               state_reg <= ST_SAMPLE;
         end
         ST_SAMPLE:
         begin
            ota_reg <= strap_sync[1];
            run_low_reg <= !strap_sync[0];
            module_reset <= 1'b0;
            hold_cnt_reg <= 32'h0000_0000;
            state_reg <= ST_RUN;
         end
         ST_RUN:
         begin
            if (reset_low_seen)
            begin
               if (hold_cnt_reg == RESET_HOLD_CYCLES - 32'h0000_0001)
               begin
                  state_reg <= ST_HOLD;
                  module_reset <= 1'b1;
               end
               else
                  hold_cnt_reg <= hold_cnt_reg + 32'h0000_0001;
            end
            else
               hold_cnt_reg <= 32'h0000_0000;
         end
         default:
         begin
            state_reg <= ST_SAMPLE;
            module_reset <= 1'b1;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////////////
// Boot mode decision.

always @(posedge clk_sys)
begin
   if (srst || module_reset)
   begin
      boot_mode <= `MODE_COMMAND;
      bridge_active <= 1'b0;
   end
   else if (ota_reg && !run_low_reg)
   begin
      boot_mode <= `MODE_BRIDGE;
      bridge_active <= 1'b1;
   end
   else if (run_low_reg && script_stored)
   begin
      boot_mode <= `MODE_AUTORUN;
      bridge_active <= 1'b0;
   end
   else if (!script_stored)
   begin
      boot_mode <= `MODE_COMMAND;
      bridge_active <= 1'b0;
   end
   else
   begin
      boot_mode <= `MODE_DEVELOP;
      bridge_active <= 1'b0;
   end
end

assign cmd_accept = cmd_request && !bridge_active && !module_reset;
assign script_load_accept = script_load_request && !bridge_active && !module_reset;

////////////////////////////////////////////////////////////////////////////////
// Pin configuration registers.

// Autorun firmware leaves pins five to eight as plain digital pins.
assign uart_on = uart_open && (boot_mode != `MODE_AUTORUN);

function is_alt;
   input integer idx;
   input uart_en, spi_en, i2c_en, flash_en; // Passed in so the mask follows every change.
   begin
      is_alt = ((idx == `PIN_RTS || idx == `PIN_TX || idx == `PIN_CTS || idx == `PIN_RX) && uart_en)
         || ((idx == `PIN_SPI_DOUT || idx == `PIN_SPI_CLK) && spi_en)
         || ((idx == `PIN_I2C_SDA || idx == `PIN_I2C_SCL) && i2c_en)
         || ((idx == `PIN_FLASH_SEL || idx == `PIN_FLASH_DIN || idx == `PIN_FLASH_CLK
              || idx == `PIN_FLASH_DOUT) && flash_en);
   end
endfunction

genvar gi;
generate
   for (gi = 0; gi < `PIN_COUNT; gi = gi + 1)
   begin : g_pin
      assign alt_mask[gi] = is_alt(gi, uart_on, spi_open, i2c_open, flash_open);

      always @(posedge clk_sys)
      begin
         if (srst || module_reset)
         begin
            cfg_oe_reg[gi] <= |(`DEF_OE & (32'h0000_0001 << gi));
            cfg_out_reg[gi] <= |(`DEF_OUT & (32'h0000_0001 << gi));
            cfg_up_reg[gi] <= |(`DEF_PULL_UP & (32'h0000_0001 << gi));
            cfg_dn_reg[gi] <= |(`DEF_PULL_DN & (32'h0000_0001 << gi));
         end
         else if (sw_cfg_write[gi])
         begin
            cfg_oe_reg[gi] <= sw_oe[gi];
            cfg_out_reg[gi] <= sw_out[gi];
            cfg_up_reg[gi] <= sw_pull_up[gi];
            cfg_dn_reg[gi] <= sw_pull_dn[gi];
         end
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Pad drive: alternate functions override the software settings.

always @(posedge clk_sys)
begin
   if (srst || module_reset)
   begin
      pin_out <= `DEF_OUT;
      pin_oe <= `DEF_OE;
      pin_pull_up <= `DEF_PULL_UP;
      pin_pull_dn <= `DEF_PULL_DN;
   end
   else
   begin
      pin_out <= cfg_out_reg;
      pin_oe <= cfg_oe_reg;
      pin_pull_up <= cfg_up_reg & ~alt_mask;
      pin_pull_dn <= cfg_dn_reg & ~alt_mask;
      if (uart_on)
      begin
         pin_out[`PIN_TX] <= uart_tx;
         pin_oe[`PIN_TX] <= 1'b1;
         pin_out[`PIN_RTS] <= uart_rts_low;
         pin_oe[`PIN_RTS] <= 1'b1;
         pin_oe[`PIN_RX] <= 1'b0;
         pin_oe[`PIN_CTS] <= 1'b0;
      end
      if (spi_open)
      begin
         pin_out[`PIN_SPI_CLK] <= spi_clk;
         pin_oe[`PIN_SPI_CLK] <= 1'b1;
         pin_out[`PIN_SPI_DOUT] <= spi_dout;
         pin_oe[`PIN_SPI_DOUT] <= 1'b1;
      end
      if (i2c_open)
      begin
         // Open drain: the lines rely on external pull-up resistors.
         pin_out[`PIN_I2C_SCL] <= 1'b0;
         pin_oe[`PIN_I2C_SCL] <= i2c_scl_oe;
         pin_out[`PIN_I2C_SDA] <= 1'b0;
         pin_oe[`PIN_I2C_SDA] <= i2c_sda_oe;
      end
      if (flash_open)
      begin
         pin_out[`PIN_FLASH_CLK] <= flash_clk;
         pin_oe[`PIN_FLASH_CLK] <= 1'b1;
         pin_out[`PIN_FLASH_DOUT] <= flash_dout;
         pin_oe[`PIN_FLASH_DOUT] <= 1'b1;
         pin_out[`PIN_FLASH_SEL] <= flash_sel_low;
         pin_oe[`PIN_FLASH_SEL] <= 1'b1;
         pin_oe[`PIN_FLASH_DIN] <= 1'b0;
      end
   end
end

// Idle-high receive and deasserted-high clear-to-send when the UART is closed.
assign uart_rx = uart_on ? pin_sync[`PIN_RX] : 1'b1;
assign uart_cts_low = uart_on ? pin_sync[`PIN_CTS] : 1'b1;
assign flash_din = flash_open ? pin_sync[`PIN_FLASH_DIN] : 1'b0;

////////////////////////////////////////////////////////////////////////////////
// RC oscillator recalibration request.

sync_pulse_timer #(
   .WIDTH(32),
   .LIMIT(CAL_INTERVAL_CYCLES)
) u_cal_timer (
   .clk_sys(clk_sys),
   .srst(srst || module_reset),
   .run(rc_osc_in_use),
   .tick(cal_tick)
);

always @(posedge clk_sys)
begin
   if (srst)
      rc_cal_pulse <= 1'b0;
   else
      rc_cal_pulse <= cal_tick;
end

endmodule
`default_nettype wire

// File: rtl/boot_strap_map.vh
`ifndef BOOT_STRAP_MAP_VH
`define BOOT_STRAP_MAP_VH

// Number of general-purpose pins handled by the pin mux.
`define PIN_COUNT 32

// Pin indices of the documented pins.
`define PIN_OTA_STRAP 2
`define PIN_RTS 5
`define PIN_TX 6
`define PIN_CTS 7
`define PIN_RX 8
`define PIN_FLASH_SEL 12
`define PIN_RUN_STRAP 13
`define PIN_FLASH_DIN 14
`define PIN_FLASH_CLK 16
`define PIN_FLASH_DOUT 20
`define PIN_SPI_DOUT 23
`define PIN_SPI_CLK 25
`define PIN_I2C_SDA 26
`define PIN_I2C_SCL 27

// Pin defaults after reset: output enable, output level, pull-up, pull-down.
`define DEF_OE 32'h0000_0060
`define DEF_OUT 32'h0000_0040
`define DEF_PULL_UP 32'hffff_d91b
`define DEF_PULL_DN 32'h0000_2084

// Timing: system clock period in ns, reset hold in ms, calibration interval in s.
`define CLK_PERIOD_NS 10
`define RESET_HOLD_MS 100
`define RESET_HOLD_CYCLES ((`RESET_HOLD_MS * 1000000) / `CLK_PERIOD_NS)
`define CAL_INTERVAL_S 8
`define CAL_INTERVAL_CYCLES (`CAL_INTERVAL_S * (1000000000 / `CLK_PERIOD_NS))

// Boot modes, one-hot.
`define MODE_WIDTH 4
`define MODE_AUTORUN 4'h1
`define MODE_COMMAND 4'h2
`define MODE_DEVELOP 4'h4
`define MODE_BRIDGE 4'h8

`endif

// File: rtl/sync_pulse_timer.v
`timescale 1ns/1ns
`default_nettype none

// Counts enabled cycles and pulses once every LIMIT cycles.
module sync_pulse_timer #(
   parameter WIDTH = 32,
   parameter [WIDTH-1:0] LIMIT = 32'd10
)
(
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Control
   input wire run,
   // Result
   output reg tick
);

reg [WIDTH-1:0] count_reg;

always @(posedge clk_sys)
begin
   if (srst || !run)
   begin
      count_reg <= {WIDTH{1'b0}};
      tick <= 1'b0;
   end
   else if (count_reg == LIMIT - 1'b1)
   begin
      count_reg <= {WIDTH{1'b0}};
      tick <= 1'b1;
   end
   else
   begin
      count_reg <= count_reg + 1'b1;
      tick <= 1'b0;
   end
end

endmodule
`default_nettype wire

// File: rtl/pin_sync2.v
`timescale 1ns/1ns
`default_nettype none

// Two-flop synchroniser for a bundle of pin inputs.
module pin_sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = 1'b0
)
(
   // Clock and reset
   input wire clk_sys,
   input wire srst,
   // Pins
   input wire [WIDTH-1:0] async_in,
   // Synchronised result
   output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_reg;

always @(posedge clk_sys)
begin
   if (srst)
   begin
      meta_reg <= INIT;
      sync_out <= INIT;
   end
   else
   begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
   end
end

endmodule
`default_nettype wire

// File: bench/boot_strap_pin_defaults_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module boot_strap_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Requests
   input wire logic cmd_request,
   input wire logic script_load_request,
   input wire logic i2c_open,
   input wire logic spi_open,
   input wire logic rc_osc_in_use,
   // Outputs
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pin_pull_up,
   input wire logic [31:0] pin_pull_dn,
   input wire logic [3:0] boot_mode,
   input wire logic module_reset,
   input wire logic bridge_active,
   input wire logic cmd_accept,
   input wire logic script_load_accept,
   input wire logic rc_cal_pulse
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   pad_dir_a: assert property (module_reset |=> pin_oe == 32'h0000_0060 && pin_out == 32'h0000_0040)
      else $error("pad direction default lost");
   pad_pull_a: assert property (module_reset |=> pin_pull_up == 32'hffff_d91b && pin_pull_dn == 32'h0000_2084)
      else $error("pad pull default lost");
   bridge_refuse_a: assert property (bridge_active || module_reset |-> !cmd_accept && !script_load_accept)
      else $error("request accepted while refused");
   request_take_a: assert property (!bridge_active && !module_reset |->
      cmd_accept == cmd_request && script_load_accept == script_load_request)
      else $error("request not accepted");
   mode_hold_a: assert property (!module_reset [*3] |-> $stable(boot_mode) && $stable(bridge_active))
      else $error("boot mode changed after sampling");
   bridge_mode_a: assert property (!module_reset [*2] |-> bridge_active == (boot_mode == 4'h8))
      else $error("bridge flag disagrees with mode");
   cal_space_a: assert property (rc_cal_pulse |=> !rc_cal_pulse [*8])
      else $error("calibration pulses too close");
   cal_idle_a: assert property (!rc_osc_in_use |=> ##1 !rc_cal_pulse)
      else $error("calibration without oscillator");
   i2c_pull_a: assert property ((i2c_open && !module_reset) [*3] |-> (pin_pull_up[27:26] | pin_pull_dn[27:26]) == 2'b00)
      else $error("pull left on two-wire pin");
   spi_pull_a: assert property ((spi_open && !module_reset) [*3] |-> ({pin_pull_up[25], pin_pull_up[23]}) == 2'b00)
      else $error("pull left on serial pin");
endmodule
bind boot_strap_pin_defaults boot_strap_checker chk_u (.clk_sys(clk_sys), .srst(srst), .cmd_request(cmd_request),
   .script_load_request(script_load_request), .i2c_open(i2c_open), .spi_open(spi_open),
   .rc_osc_in_use(rc_osc_in_use), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
   .pin_pull_dn(pin_pull_dn), .boot_mode(boot_mode), .module_reset(module_reset), .bridge_active(bridge_active),
   .cmd_accept(cmd_accept), .script_load_accept(script_load_accept), .rc_cal_pulse(rc_cal_pulse));
`default_nettype wire

// File: bench/host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
   // Clock
   input wire logic clk_sys,
   // Pad controls
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_pull_up,
   input wire logic [31:0] pin_pull_dn,
   // Pad levels
   output logic [31:0] pin_in,
   output logic system_reset_low,
   output logic ota_download_strap,
   output logic run_mode_strap_low
);
   logic [31:0] drv_en = 32'h0;
   logic [31:0] drv_val = 32'h0;
   logic rst_low = 1'b1;
   logic [31:0] noise = 32'h5555_aaaa;
   // A floating pad toggles so that it never passes for a steady level.
   always @(posedge clk_sys)
      noise <= ~noise;
   always_comb
      for (int i = 0; i < 32; i++)
         // The host's transmit line idles high and its ready line stays asserted.
         pin_in[i] = pin_oe[i] ? pin_out[i] : drv_en[i] ? drv_val[i] : (i == 26 || i == 27) ? 1'b1 :
            (i == 8) ? 1'b1 : (i == 7) ? 1'b0 :
            pin_pull_up[i] ? 1'b1 : pin_pull_dn[i] ? 1'b0 : noise[i];
   assign system_reset_low = rst_low;
   assign ota_download_strap = pin_in[2];
   assign run_mode_strap_low = pin_in[13];
   task automatic hold_reset(input int n);
      rst_low = 1'b0;
      repeat (n) @(posedge clk_sys);
      #1 rst_low = 1'b1;
   endtask
endmodule
`default_nettype wire

// File: bench/boot_strap_pin_defaults_tb.sv
`timescale 1ns/1ns
`default_nettype none
module boot_strap_pin_defaults_tb;
   // Rows: strap drive, ota level, run level, script stored, expected mode.
   localparam logic [7:0] boot_tbl [6] = '{8'h91, 8'hb4, 8'h82, 8'hf8, 8'he8, 8'h11};
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   // Script, uart, spi, i2c, flash, rc osc, command request, script load request.
   logic [7:0] ctl = 8'h03;
   logic [8:0] per = 9'h1ff;
   logic [31:0] wr = 32'h0;
   logic [31:0] pu = 32'h0;
   logic [31:0] pd = 32'h0;
   logic [31:0] oe_w = 32'h0;
   logic [31:0] out_w = 32'h0;
   int cmp_count = 0;
   int fail_count = 0;
   int n;
   wire [31:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_dn;
   wire [3:0] boot_mode;
   wire rst_low, ota, run_low, uart_rx, cts_low, flash_din, module_reset;
   wire bridge_active, cmd_accept, script_load_accept, rc_cal_pulse;
   boot_strap_pin_defaults #(.RESET_HOLD_CYCLES(32'd20), .CAL_INTERVAL_CYCLES(32'd16)) dut (
      .clk_sys(clk_sys), .srst(srst), .system_reset_low(rst_low), .ota_download_strap(ota),
      .run_mode_strap_low(run_low), .script_stored(ctl[7]), .uart_open(ctl[6]), .spi_open(ctl[5]),
      .i2c_open(ctl[4]), .flash_open(ctl[3]), .rc_osc_in_use(ctl[2]), .cmd_request(ctl[1]),
      .script_load_request(ctl[0]), .sw_cfg_write(wr), .sw_oe(oe_w), .sw_out(out_w), .sw_pull_up(pu),
      .sw_pull_dn(pd), .uart_tx(per[8]), .uart_rts_low(per[7]), .spi_clk(per[6]), .spi_dout(per[5]),
      .i2c_scl_oe(per[4]), .i2c_sda_oe(per[3]), .flash_clk(per[2]), .flash_dout(per[1]),
      .flash_sel_low(per[0]), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn), .uart_rx(uart_rx), .uart_cts_low(cts_low),
      .flash_din(flash_din), .boot_mode(boot_mode), .module_reset(module_reset), .bridge_active(bridge_active),
      .cmd_accept(cmd_accept), .script_load_accept(script_load_accept), .rc_cal_pulse(rc_cal_pulse));
   host_model host (.clk_sys(clk_sys), .pin_oe(pin_oe), .pin_out(pin_out), .pin_pull_up(pin_pull_up),
      .pin_pull_dn(pin_pull_dn), .pin_in(pin_in), .system_reset_low(rst_low), .ota_download_strap(ota),
      .run_mode_strap_low(run_low));
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_def;
      chk(pin_oe, 32'h0000_0060);
      chk(pin_out, 32'h0000_0040);
      chk(pin_pull_up, 32'hffff_d91b);
      chk(pin_pull_dn, 32'h0000_2084);
   endtask
   task automatic wait_run;
      for (int k = 0; k < 40 && module_reset !== 1'b0; k++)
         cyc(1);
      cyc(1);
   endtask
   // Straps are set before reset so they are steady through the synchronisers.
   task automatic boot(input logic [7:0] r);
      host.drv_en[2] = r[7];
      host.drv_en[13] = r[7];
      host.drv_val[2] = r[6];
      host.drv_val[13] = r[5];
      ctl[7] = r[4];
      srst = 1'b1;
      cyc(5);
      srst = 1'b0;
      wait_run();
   endtask
   task automatic gap(output int k);
      k = 0;
      do
      begin
         cyc(1);
         k++;
      end
      while (rc_cal_pulse !== 1'b1 && k < 40);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #50000;
      fail_count++;
      end_of_test();
   end
   initial
   begin
      foreach (boot_tbl[i])
      begin
         boot(boot_tbl[i]);
         chk(boot_mode, boot_tbl[i][3:0]);
         chk({cmd_accept, script_load_accept}, {2{~boot_tbl[i][3]}});
         host.drv_val[13] = ~host.drv_val[13];
         cyc(6);
         chk(boot_mode, boot_tbl[i][3:0]);
      end
      chk_def();
      $display("test boot modes done");
      ctl[6] = 1'b1;
      per[8] = 1'b0;
      cyc(3);
      chk({pin_oe[8:5], pin_out[6], cts_low}, 6'h0f);
      boot(8'h82);
      cyc(3);
      chk({pin_out[6], uart_rx, cts_low}, 3'b010);
      $display("test uart pins done");
      oe_w[3] = 1'b1;
      out_w[3] = 1'b1;
      wr[3] = 1'b1;
      cyc(1);
      wr = 32'h0;
      cyc(2);
      chk({pin_pull_up[3], pin_oe[3], pin_out[3]}, 3'b011);
      host.hold_reset(15);
      chk(module_reset, 1'b0);
      host.hold_reset(30);
      chk(module_reset, 1'b1);
      chk_def();
      wait_run();
      chk(boot_mode, 4'h2);
      $display("test pin reset done");
      host.drv_en[14] = 1'b1;
      host.drv_val[14] = 1'b1;
      cyc(3);
      chk(flash_din, 1'b0);
      ctl[5:3] = 3'b111;
      cyc(3);
      chk({pin_oe[20], pin_oe[16], pin_oe[12], flash_din}, 4'hf);
      wr = 32'h0480_0000;
      pu = 32'hffff_ffff;
      pd = 32'hffff_ffff;
      cyc(1);
      wr = 32'h0;
      cyc(2);
      chk((pin_pull_up | pin_pull_dn) & 32'h0e80_0000, 32'h0);
      $display("test alternate pins done");
      ctl[2] = 1'b1;
      gap(n);
      gap(n);
      chk(n, 16);
      ctl[2] = 1'b0;
      gap(n);
      chk(n, 40);
      $display("test calibration done");
      end_of_test();
   end
endmodule
`default_nettype wire
